// *** bmpp_regs.svh ***
// timing counts, field positions and sizes for the base-memory page and prefetch block
`ifndef BMPP_REGS_SVH
`define BMPP_REGS_SVH
`define BMPP_PAGE_KEEP_BIT   7
`define BMPP_ALIAS_BIT       28
`define BMPP_WORD_LSB        2
`define BMPP_PAGE_LSB_ILV    11
`define BMPP_PAGE_LSB_NILV   10
`define BMPP_PRECHARGE_NS    15
`define BMPP_RAS_CAS_NS      20
`define BMPP_CAS_PULSE_NS    10
`define BMPP_CLK_PERIOD_NS   5
`define BMPP_SEQ_EARLY_CLKS  3
`define BMPP_CEIL_CYC(ns)    (((ns) + `BMPP_CLK_PERIOD_NS - 1) / `BMPP_CLK_PERIOD_NS)
`define BMPP_PRECHARGE_CYC   `BMPP_CEIL_CYC(`BMPP_PRECHARGE_NS)
`define BMPP_RAS_CAS_CYC     `BMPP_CEIL_CYC(`BMPP_RAS_CAS_NS)
`define BMPP_CAS_PULSE_CYC   `BMPP_CEIL_CYC(`BMPP_CAS_PULSE_NS)
`define BMPP_NORMAL_LAT      (`BMPP_PRECHARGE_CYC + `BMPP_RAS_CAS_CYC + `BMPP_CAS_PULSE_CYC)
`endif

// *** bmpp_pkg.sv ***
// types shared by the base-memory page and prefetch block
package bmpp_pkg;
  typedef enum logic [2:0] {
    BMPP_IDLE,
    BMPP_PRECHARGE,
    BMPP_ROW,
    BMPP_CAS,
    BMPP_FETCH,
    BMPP_DONE
  } bmpp_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bmpp_req_t;

  typedef struct packed {
    logic        row_n;
    logic        col_n;
    logic        we_n;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bmpp_mem_t;
endpackage

// *** bmpp_ctrl.sv ***
// base-memory page-mode and read-prefetch controller
`timescale 1ns/1ps
`include "bmpp_regs.svh"

module bmpp_ctrl
  import bmpp_pkg::*;
#(
  parameter int unsigned PF_WORDS = 2
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // configuration
  input  wire logic        i_page_keep_enable,
  input  wire logic        i_interleave,
  // cpu side request and answer
  input  wire bmpp_req_t   i_req,
  input  wire logic        i_other_access,
  output logic             o_ready,
  output logic             o_ack,
  output logic             o_seq_hit,
  output logic [31:0]      o_rdata,
  // dram side
  output logic             o_row_strobe_n,
  output logic             o_column_strobe_n,
  output logic             o_we_n,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_wdata,
  input  wire logic [31:0] i_mem_rdata
);

  localparam int unsigned CW = 4;
  localparam logic [CW-1:0] PRE_C  = CW'(`BMPP_PRECHARGE_CYC);
  localparam logic [CW-1:0] RC_C   = CW'(`BMPP_RAS_CAS_CYC);
  localparam logic [CW-1:0] CAS_C  = CW'(`BMPP_CAS_PULSE_CYC);
  localparam logic [CW-1:0] SEQ_C  = CW'(`BMPP_NORMAL_LAT - `BMPP_SEQ_EARLY_CLKS);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    bmpp_state_t        st;
    logic [CW-1:0]      cnt;
    bmpp_req_t          cur;
    logic               keep;
    logic               page_open;
    logic [31:0]        page_row;
    logic               row_ilv;
    bmpp_mem_t          mem;
    logic [1:0]         pf_idx;
    logic               pf_valid;
    logic [31:0]        pf_next;
    logic [PF_WORDS-1:0][31:0] pf_data;
    logic               seq;
    logic               ack;
    logic [31:0]        rdata;
  } bmpp_all_t;

  bmpp_all_t s_q;
  bmpp_all_t s_d;

  // bit 28 dropped from the page compare so both aliases share one page
  function automatic logic [31:0] page_of(input logic [31:0] a, input logic ilv);
    logic [31:0] m;
    m = a;
    m[`BMPP_ALIAS_BIT] = 1'b0;
    if (ilv) begin
      page_of = m >> `BMPP_PAGE_LSB_ILV;
    end else begin
      page_of = m >> `BMPP_PAGE_LSB_NILV;
    end
  endfunction

  logic        hit;
  logic        seq_rd;
  logic [31:0] next_addr;

  always_comb begin
    // a row opened under the other page size never counts as a hit
    hit = s_q.page_open && (s_q.row_ilv == i_interleave)
          && (page_of(i_req.addr, i_interleave) == s_q.page_row);
    seq_rd = s_q.pf_valid && !i_req.write && (i_req.addr == s_q.pf_next);
    next_addr = s_q.cur.addr + 32'h0000_0004;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    case (s_q.st)
      BMPP_IDLE: begin
        s_d.mem.col_n = 1'b1;
        if (i_req.valid) begin
          s_d.cur = i_req;
          s_d.seq = 1'b0;
          s_d.keep = i_page_keep_enable && i_req.addr[`BMPP_ALIAS_BIT];
          s_d.mem.addr = i_req.addr;
          s_d.mem.wdata = i_req.wdata;
          s_d.mem.we_n = !i_req.write;
          if (i_req.write) begin
            s_d.pf_valid = 1'b0;
          end
          if (seq_rd) begin
            // served from the buffer, no dram cycle
            s_d.seq = 1'b1;
            s_d.cnt = SEQ_C;
            s_d.st = BMPP_DONE;
          end else if (hit) begin
            s_d.cnt = CAS_C;
            s_d.mem.col_n = 1'b0;
            s_d.st = BMPP_CAS;
          end else begin
            s_d.cnt = PRE_C;
            s_d.mem.row_n = 1'b1;
            s_d.page_open = 1'b0;
            s_d.st = BMPP_PRECHARGE;
          end
        end
      end
      BMPP_PRECHARGE: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == 1) begin
          s_d.mem.row_n = 1'b0;
          s_d.cnt = RC_C;
          s_d.st = BMPP_ROW;
        end
      end
      BMPP_ROW: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == 1) begin
          s_d.mem.col_n = 1'b0;
          s_d.cnt = CAS_C;
          s_d.page_open = 1'b1;
          s_d.page_row = page_of(s_q.cur.addr, i_interleave);
          s_d.row_ilv = i_interleave;
          s_d.st = BMPP_CAS;
        end
      end
      BMPP_CAS: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == 1) begin
          s_d.mem.col_n = 1'b1;
          s_d.rdata = i_mem_rdata;
          s_d.ack = 1'b1;
          if (!s_q.cur.write && i_page_keep_enable) begin
            // two more words follow every read that misses the buffer while i_page_keep_enable is set; the row stays low until they are in,
            // so the page is only closed once the prefetch has finished
            s_d.pf_idx = 2'h0;
            s_d.pf_valid = 1'b0;
            s_d.mem.addr = next_addr;
            s_d.mem.we_n = 1'b1;
            s_d.st = BMPP_FETCH;
          end else begin
            s_d.st = BMPP_IDLE;
            if (!s_q.keep) begin
              s_d.mem.row_n = 1'b1;
              s_d.page_open = 1'b0;
            end // else row stays low
          end
        end
      end
      BMPP_FETCH: begin
        // fetch with one-cycle column pulses, half the page-hit CAS_C; page is still open here
        s_d.mem.col_n = !s_q.mem.col_n;
        if (!s_q.mem.col_n) begin
          s_d.pf_data[s_q.pf_idx[0]] = i_mem_rdata;
          s_d.pf_idx = s_q.pf_idx + 2'h1;
          s_d.mem.addr = s_q.mem.addr + 32'h0000_0004;
          if (s_q.pf_idx == 2'(PF_WORDS - 1)) begin
            s_d.pf_valid = 1'b1;
            s_d.pf_next = next_addr;
            s_d.mem.col_n = 1'b1;
            s_d.mem.row_n = !s_q.keep;
            if (!s_q.keep) begin
              s_d.page_open = 1'b0;
            end
            // read pointer for the words now waiting in the buffer
            s_d.pf_idx = 2'h0;
            s_d.st = BMPP_IDLE;
          end
        end
      end
      BMPP_DONE: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == 1) begin
          s_d.rdata = s_q.pf_data[s_q.pf_idx[0]];
          s_d.ack = 1'b1;
          // the next word in line may still be served from the buffer
          s_d.pf_idx = s_q.pf_idx + 2'h1;
          s_d.pf_next = s_q.pf_next + 32'h0000_0004;
          if (s_q.pf_idx == 2'(PF_WORDS - 1)) begin
            s_d.pf_valid = 1'b0;
          end
          if (!s_q.keep) begin
            s_d.mem.row_n = 1'b1;
            s_d.page_open = 1'b0;
          end
          s_d.st = BMPP_IDLE;
        end
      end
      default: s_d.st = BMPP_IDLE;
    endcase
    if (i_other_access) begin
      s_d.pf_valid = s_d.pf_valid;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= BMPP_IDLE;
      s_q.mem.row_n <= 1'b1;
      s_q.mem.col_n <= 1'b1;
      s_q.mem.we_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_ready = (s_q.st == BMPP_IDLE);
  assign o_ack = s_q.ack;
  assign o_seq_hit = s_q.seq;
  assign o_rdata = s_q.rdata;
  assign o_row_strobe_n = s_q.mem.row_n;
  assign o_column_strobe_n = s_q.mem.col_n;
  assign o_we_n = s_q.mem.we_n;
  assign o_mem_addr = s_q.mem.addr;
  assign o_mem_wdata = s_q.mem.wdata;

  // ************************************************************
  // checks
  // ************************************************************
  hit_no_row_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_ready && i_req.valid && hit && !seq_rd) |=> s_q.st == BMPP_CAS && !o_row_strobe_n)
    else $error("page hit dropped row strobe");
  miss_precharge_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_ready && i_req.valid && !hit && !seq_rd) |=> o_row_strobe_n && !s_q.page_open)
    else $error("page miss without precharge");
  keep_open_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_q.st == BMPP_CAS && s_q.cnt == 1 && s_q.keep) |=> !o_row_strobe_n)
    else $error("page not held open");
  close_page_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!o_ready && s_d.st == BMPP_IDLE && !s_q.keep) |=> o_row_strobe_n)
    else $error("page not closed");
  write_flush_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_ready && i_req.valid && i_req.write) |=> !s_q.pf_valid)
    else $error("prefetch kept over write");
  seq_early_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_ready && i_req.valid && seq_rd) |=> ##6 o_ack)
    else $error("sequential read not early");
  keep_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_ready && i_req.valid && !i_page_keep_enable) |=> !s_q.keep)
    else $error("page kept while disabled");
  fetch_two_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_q.st == BMPP_CAS && s_q.cnt == 1 && !s_q.cur.write && i_page_keep_enable)
    |=> s_q.st == BMPP_FETCH ##4 s_q.pf_valid)
    else $error("two-word prefetch missing");
  track_page_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_row_strobe_n && o_ready |-> !s_q.page_open)
    else $error("page tracked while closed");
  alias_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_ready && i_req.valid && !i_req.addr[`BMPP_ALIAS_BIT]) |=> !s_q.keep)
    else $error("page kept without bit 28");
  hit_time_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_ready && i_req.valid && hit && !seq_rd) |=> !o_column_strobe_n ##2 o_ack)
    else $error("page hit not answered in time");
  miss_time_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_ready && i_req.valid && !hit && !seq_rd) |=> ##9 o_ack)
    else $error("page miss not answered in time");
  precharge_high_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_q.st == BMPP_PRECHARGE) |-> o_row_strobe_n)
    else $error("row strobe low in precharge");
  col_idle_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_ready |-> o_column_strobe_n)
    else $error("column strobe low while idle");
  fetch_row_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_q.st == BMPP_FETCH) |-> !o_row_strobe_n && s_q.page_open)
    else $error("prefetch without an open row");
  seq_data_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_q.st == BMPP_DONE && s_q.cnt == 1 && !s_q.pf_idx[0])
    |=> o_ack && o_seq_hit && (o_rdata == $past(s_q.pf_data[0])))
    else $error("buffered word not returned");
  other_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_ready && !i_req.valid && i_other_access && s_q.pf_valid) |=> s_q.pf_valid)
    else $error("prefetch lost on other access");

endmodule

// *** bmpp_dram_model.sv ***
// edo memory model answering the controller's row and column strobes
`timescale 1ns/1ps
module bmpp_dram_model (
  input  wire logic        i_row_strobe_n,
  input  wire logic        i_column_strobe_n,
  input  wire logic        i_we_n,
  input  wire logic [31:0] i_mem_addr,
  input  wire logic [31:0] i_mem_wdata,
  output logic [31:0]      o_mem_rdata
);
  logic [31:0] mem_q [0:1023];
  logic [9:0]  idx;
  // bit 28 never reaches the index, so both ranges alias
  assign idx = i_mem_addr[11:2];
  initial begin
    for (int i = 0; i < 1024; i++) mem_q[i] = 32'ha5000000 + 32'(i);
  end
  always @(negedge i_column_strobe_n) begin
    if (!i_we_n && !i_row_strobe_n) mem_q[idx] = i_mem_wdata;
  end
  // outside a column pulse the lines show junk, not the last word
  assign o_mem_rdata = (!i_row_strobe_n && !i_column_strobe_n) ? mem_q[idx] : ~mem_q[idx];
endmodule

// *** bmpp_ctrl_bench.sv ***
// self-checking bench for the base-memory page and prefetch controller
`timescale 1ns/1ps
module bmpp_ctrl_bench;
  import bmpp_pkg::*;
  logic        i_core_clk;
  logic        i_rst;
  logic        keep_en;
  logic        ilv;
  bmpp_req_t   req;
  logic        other;
  logic        ready;
  logic        ack;
  logic        seq_hit;
  logic        row_n;
  logic        col_n;
  logic        we_n;
  logic [31:0] rdata;
  logic [31:0] maddr;
  logic [31:0] mwdata;
  logic [31:0] mrdata;
  logic [31:0] ref_q [0:1023];
  int          failures;
  int          check_count;

  bmpp_ctrl dut_u (
    .i_core_clk         (i_core_clk),
    .i_rst              (i_rst),
    .i_page_keep_enable (keep_en),
    .i_interleave       (ilv),
    .i_req              (req),
    .i_other_access     (other),
    .o_ready            (ready),
    .o_ack              (ack),
    .o_seq_hit          (seq_hit),
    .o_rdata            (rdata),
    .o_row_strobe_n     (row_n),
    .o_column_strobe_n  (col_n),
    .o_we_n             (we_n),
    .o_mem_addr         (maddr),
    .o_mem_wdata        (mwdata),
    .i_mem_rdata        (mrdata)
  );
  bmpp_dram_model mem_u (
    .i_row_strobe_n    (row_n),
    .i_column_strobe_n (col_n),
    .i_we_n            (we_n),
    .i_mem_addr        (maddr),
    .i_mem_wdata       (mwdata),
    .o_mem_rdata       (mrdata)
  );

  // ********************
  // helpers
  // ********************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick;
    @(posedge i_core_clk);
    #1;
  endtask
  task automatic wait_ready;
    int n;
    for (n = 0; n < 40 && ready !== 1'b1; n++) tick;
    if (n == 40) begin
      failures++;
      finish_test;
    end
  endtask
  // one access: cycles to ack, data, prefetch flag, row strobe once idle
  task automatic xfer(input logic w, input logic [31:0] a, input int lat,
                      input logic sq, input logic keep);
    int n;
    n = 0;
    wait_ready;
    req = '{1'b1, w, a, 32'h5a000000 ^ a};
    tick;
    req.valid = 1'b0;
    do begin
      tick;
      n++;
    end while (ack !== 1'b1 && n < 40);
    cmp(32'(n), 32'(lat));
    if (ack !== 1'b1) finish_test;
    if (!w) cmp(rdata, ref_q[a[11:2]]);
    else ref_q[a[11:2]] = 32'h5a000000 ^ a;
    cmp({31'h0, seq_hit}, {31'h0, sq});
    wait_ready;
    cmp({31'h0, row_n}, {31'h0, !keep});
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic test_page_size;
    ilv = 1'b1;
    xfer(1'b0, 32'h10000000, 9, 1'b0, 1'b1);
    xfer(1'b0, 32'h10000500, 2, 1'b0, 1'b1);
    ilv = 1'b0;
    xfer(1'b0, 32'h10000300, 9, 1'b0, 1'b1);
    $display("test_page_size done");
  endtask
  task automatic test_prefetch;
    xfer(1'b0, 32'h10000304, 6, 1'b1, 1'b1);
    other = 1'b1;
    tick;
    other = 1'b0;
    xfer(1'b0, 32'h10000308, 6, 1'b1, 1'b1);
    xfer(1'b1, 32'h10000700, 9, 1'b0, 1'b1);
    xfer(1'b0, 32'h1000030c, 9, 1'b0, 1'b1);
    xfer(1'b1, 32'h10000704, 9, 1'b0, 1'b1);
    xfer(1'b0, 32'h10000310, 9, 1'b0, 1'b1);
    $display("test_prefetch done");
  endtask
  task automatic test_close;
    xfer(1'b0, 32'h00000700, 9, 1'b0, 1'b0);
    xfer(1'b0, 32'h10000310, 9, 1'b0, 1'b1);
    xfer(1'b0, 32'h00000320, 2, 1'b0, 1'b0);
    keep_en = 1'b0;
    xfer(1'b0, 32'h10000000, 9, 1'b0, 1'b0);
    xfer(1'b0, 32'h10000004, 9, 1'b0, 1'b0);
    $display("test_close done");
  endtask

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  initial begin
    failures = 0;
    check_count = 0;
    i_rst = 1'b1;
    keep_en = 1'b1;
    ilv = 1'b1;
    req = '0;
    other = 1'b0;
    for (int i = 0; i < 1024; i++) ref_q[i] = 32'ha5000000 + 32'(i);
    repeat (8) tick;
    i_rst = 1'b0;
    cmp({30'h0, row_n, ready}, 32'h3);
    test_page_size;
    test_prefetch;
    test_close;
    finish_test;
  end
endmodule
